// *** core/eoc_osc_div.sv ***
// divider turning oscillator edges into a peripheral clock tick
`timescale 1ns/1ps
module eoc_osc_div (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // oscillator edge stream
  input  wire logic osc_edge,
  input  wire logic run,
  input  wire logic half_rate,
  // one-cycle tick per eight (or sixteen) edges
  output logic      tick
);

  typedef struct packed {
    logic [3:0] cnt;
    logic       tick;
  } eoc_div_t;

  eoc_div_t r_reg;
  eoc_div_t r_next;
  logic [3:0] last;

  // half rate raises the terminal count from 7 to 15, doubling the edges per tick
  assign last = half_rate ? eoc_pkg::DIV16_LAST : eoc_pkg::DIV8_LAST;

  // tick lands on the system_clock_source edge after the osc edge is seen
  always_comb begin
    r_next      = r_reg;
    r_next.tick = 1'b0;
    if (!run) begin
      r_next.cnt = 4'h0;
    end else if (osc_edge) begin
      if (r_reg.cnt >= last) begin
        r_next.cnt  = 4'h0;
        r_next.tick = 1'b1;
      end else begin
        r_next.cnt = r_reg.cnt + 4'h1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign tick = r_reg.tick;

endmodule

// *** core/eoc_pkg.sv ***
// shared constants and types for the external oscillator control block
package eoc_pkg;

  // system clock rate
  localparam int CLK_MHZ = 40;
  localparam int CLK_KHZ = 40000;

  // register byte offsets on the apb window
  localparam logic [11:0] OFS_CTRL  = 12'h000;
  localparam logic [11:0] OFS_MEAS  = 12'h004;
  localparam logic [11:0] OFS_CAP0  = 12'h008;
  localparam logic [11:0] OFS_CAP1  = 12'h00C;

  // ext_osc_control_reg field layout
  localparam int CTRL_VALID_BIT = 7;
  localparam int CTRL_MODE_LSB  = 4;
  localparam int CTRL_FCN_LSB   = 0;
  localparam logic [2:0] MODE_RESET = 3'h0;
  localparam logic [2:0] FCN_RESET  = 3'h0;

  // measurement control field layout
  localparam int MEAS_EN_LSB = 0;
  localparam logic [1:0] MEAS_RESET = 2'h0;

  // oscillator mode codes
  localparam logic [2:0] MODE_OFF0      = 3'h0;
  localparam logic [2:0] MODE_OFF1      = 3'h1;
  localparam logic [2:0] MODE_CMOS      = 3'h2;
  localparam logic [2:0] MODE_CMOS_DIV2 = 3'h3;
  localparam logic [2:0] MODE_RC        = 3'h4;
  localparam logic [2:0] MODE_CAP       = 3'h5;
  localparam logic [2:0] MODE_XTAL      = 3'h6;
  localparam logic [2:0] MODE_XTAL_DIV2 = 3'h7;

  // crystal amplitude settling time and its cycle count
  localparam int XTAL_SETTLE_TIME_MS = 1;
  localparam int XTAL_SETTLE_CYCLES  = XTAL_SETTLE_TIME_MS * CLK_KHZ;

  // oscillator deemed stopped after this long without an edge
  localparam int OSC_LOSS_TIME_US = 100;
  localparam logic [12:0] OSC_LOSS_CYCLES = 13'(OSC_LOSS_TIME_US * CLK_MHZ);

  // peripheral clock divider terminal counts
  localparam logic [3:0] DIV8_LAST  = 4'h7;
  localparam logic [3:0] DIV16_LAST = 4'hF;

  // crystal valid tracking states
  typedef enum logic [1:0] {
    EOC_V_IDLE,
    EOC_V_SETTLE,
    EOC_V_VALID
  } eoc_vstate_t;

endpackage

// *** core/eoc_sync.sv ***
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module eoc_sync #(
  parameter int W = 2
) (
  // clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // asynchronous in, synchronous out
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } eoc_sync_t;

  eoc_sync_t r_reg;
  eoc_sync_t r_next;

  // first stage feeds only the second
  always_comb begin
    r_next        = r_reg;
    r_next.meta   = async_in;
    r_next.stable = r_reg.meta;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign sync_out = r_reg.stable;

endmodule

// *** core/eoc_top.sv ***
// external oscillator control: apb registers, pin takeover, valid flag, div8
// Functional notes
// - offer oscillator divided by eight to timers
// - synchronise divided clock, jitter within half cycle (rising-edge sampling here gives up to one pclk cycle)
// - crystal mode takes both crystal pins
// - rc, cap, cmos modes take output pin only
// - higher rc frequency control improves accuracy
// - measure oscillator against rtc with two timers
//
// Our own choices: the APB register port and the register addresses.
`timescale 1ns/1ps
module eoc_top #(
  parameter int SETTLE_CYCLES = eoc_pkg::XTAL_SETTLE_CYCLES
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // oscillator and rtc clocks from pins
  input  wire logic        ext_osc_in,
  input  wire logic        rtc_osc_in,
  // pin takeover toward the port logic
  output logic             crystal_in_pin_owned,
  output logic             crystal_out_pin_owned,
  // analog drive control
  output logic             osc_enable,
  output logic      [2:0]  osc_mode,
  output logic      [2:0]  ext_osc_freq_control,
  // status and peripheral clock
  output logic             crystal_valid_flag,
  output logic             ext_osc_div8_tick
);

  typedef struct packed {
    logic [31:0]      prdata;
    logic             pready;
    logic             pslverr;
    logic [2:0]       mode;
    logic [2:0]       fcn;
    logic [1:0]       cap_en;
    logic [15:0]      edge_cnt;
    logic [1:0][15:0] cap;
    logic             osc_d;
    logic             rtc_d;
    eoc_pkg::eoc_vstate_t vstate;
    logic [15:0]      settle_cnt;
    logic [12:0]      idle_cnt;
    logic             valid;
    logic             own_in;
    logic             own_out;
    logic             osc_en;
  } eoc_state_t;

  eoc_state_t r_reg;
  eoc_state_t r_next;

  logic [1:0]       pins_s;
  logic             osc_s;
  logic             rtc_s;
  logic             osc_edge;
  logic             rtc_edge;
  logic             crystal;
  logic             lost;
  logic             running;
  logic             half_rate;
  logic             div_tick;
  logic             access;
  logic             mapped;
  logic             wr_ctrl;
  logic             wr_meas;
  logic [31:0]      rd_word;
  logic [1:0][15:0] cap_upd;

  // pins come from outside the system_clock_source domain
  eoc_sync #(
    .W (2)
  ) u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in ({rtc_osc_in, ext_osc_in}),
    .sync_out (pins_s)
  );

  assign osc_s = pins_s[0];
  assign rtc_s = pins_s[1];

  // edge detection works on the second stage only
  assign osc_edge = osc_s & ~r_reg.osc_d;
  assign rtc_edge = rtc_s & ~r_reg.rtc_d;

  // mode decode; every code spelled out so none falls through unseen
  always_comb begin
    running   = 1'b0;
    crystal   = 1'b0;
    half_rate = 1'b0;
    case (r_reg.mode)
      eoc_pkg::MODE_OFF0, eoc_pkg::MODE_OFF1: begin
        running   = 1'b0;
        crystal   = 1'b0;
        half_rate = 1'b0;
      end
      eoc_pkg::MODE_CMOS, eoc_pkg::MODE_RC, eoc_pkg::MODE_CAP: begin
        running   = 1'b1;
        crystal   = 1'b0;
        half_rate = 1'b0;
      end
      eoc_pkg::MODE_CMOS_DIV2: begin
        running   = 1'b1;
        crystal   = 1'b0;
        half_rate = 1'b1;
      end
      eoc_pkg::MODE_XTAL: begin
        running   = 1'b1;
        crystal   = 1'b1;
        half_rate = 1'b0;
      end
      eoc_pkg::MODE_XTAL_DIV2: begin
        running   = 1'b1;
        crystal   = 1'b1;
        half_rate = 1'b1;
      end
      default: begin
        running   = 1'b0;
        crystal   = 1'b0;
        half_rate = 1'b0;
      end
    endcase
  end

  // oscillator deemed stopped once the watchdog saturates
  assign lost = r_reg.idle_cnt >= eoc_pkg::OSC_LOSS_CYCLES;

  // divided clock: edges sampled on rising pclk give up to one pclk cycle of jitter
  eoc_osc_div u_div (
    .pclk      (pclk),
    .presetn   (presetn),
    .osc_edge  (osc_edge),
    .run       (running),
    .half_rate (half_rate),
    .tick      (div_tick)
  );

  // apb decode; writes commit on the edge that samples pready high
  assign access  = psel && penable && r_reg.pready;
  assign mapped  = (paddr == eoc_pkg::OFS_CTRL) || (paddr == eoc_pkg::OFS_MEAS)
                || (paddr == eoc_pkg::OFS_CAP0) || (paddr == eoc_pkg::OFS_CAP1);
  assign wr_ctrl = access && pwrite && (paddr == eoc_pkg::OFS_CTRL);
  assign wr_meas = access && pwrite && (paddr == eoc_pkg::OFS_MEAS);

  // read mux; bit 3 of control is reserved and reads zero
  always_comb begin
    rd_word = 32'h0000_0000;
    case (paddr)
      eoc_pkg::OFS_CTRL: begin
        rd_word[eoc_pkg::CTRL_VALID_BIT]                     = r_reg.valid & crystal;
        rd_word[eoc_pkg::CTRL_MODE_LSB +: 3]                 = r_reg.mode;
        rd_word[eoc_pkg::CTRL_FCN_LSB +: 3]                  = r_reg.fcn;
      end
      eoc_pkg::OFS_MEAS: begin
        rd_word[eoc_pkg::MEAS_EN_LSB +: 2] = r_reg.cap_en;
      end
      eoc_pkg::OFS_CAP0: begin
        rd_word[15:0] = r_reg.cap[0];
      end
      eoc_pkg::OFS_CAP1: begin
        rd_word[15:0] = r_reg.cap[1];
      end
      default: begin
        rd_word = 32'h0000_0000;
      end
    endcase
  end

  // two independent capture units latch the edge count on rtc edges
  for (genvar i = 0; i < 2; i++) begin : g_cap
    assign cap_upd[i] = (rtc_edge && r_reg.cap_en[i]) ? r_reg.edge_cnt : r_reg.cap[i];
  end

  // next-state logic for the whole block
  always_comb begin
    r_next       = r_reg;
    r_next.osc_d = osc_s;
    r_next.rtc_d = rtc_s;

    // one wait state, then the answer with data and error
    r_next.pready  = psel && penable && !r_reg.pready;
    r_next.pslverr = psel && penable && !r_reg.pready && !mapped;
    if (psel && penable && !r_reg.pready) begin
      r_next.prdata = rd_word;
    end

    // software picks mode and frequency range
    if (wr_ctrl) begin
      r_next.mode = pwdata[eoc_pkg::CTRL_MODE_LSB +: 3];
      r_next.fcn  = pwdata[eoc_pkg::CTRL_FCN_LSB +: 3];
    end
    if (wr_meas) begin
      r_next.cap_en = pwdata[eoc_pkg::MEAS_EN_LSB +: 2];
    end

    // free-running oscillator edge count for frequency measurement
    if (osc_edge) begin
      r_next.edge_cnt = r_reg.edge_cnt + 16'h0001;
    end
    r_next.cap = cap_upd;

    // watchdog on oscillator activity, saturating
    if (osc_edge) begin
      r_next.idle_cnt = 13'h0000;
    end else if (!lost) begin
      r_next.idle_cnt = r_reg.idle_cnt + 13'h0001;
    end

    // crystal valid tracking
    case (r_reg.vstate)
      eoc_pkg::EOC_V_IDLE: begin
        r_next.valid      = 1'b0;
        r_next.settle_cnt = 16'h0000;
        if (crystal) begin
          r_next.vstate = eoc_pkg::EOC_V_SETTLE;
        end
      end
      eoc_pkg::EOC_V_SETTLE: begin
        r_next.valid = 1'b0;
        if (!crystal) begin
          r_next.vstate = eoc_pkg::EOC_V_IDLE;
        end else if (lost) begin
          r_next.settle_cnt = 16'h0000;
        end else if (r_reg.settle_cnt >= 16'(SETTLE_CYCLES - 1)) begin
          r_next.vstate = eoc_pkg::EOC_V_VALID;
          r_next.valid  = 1'b1;
        end else begin
          r_next.settle_cnt = r_reg.settle_cnt + 16'h0001;
        end
      end
      eoc_pkg::EOC_V_VALID: begin
        if (!crystal) begin
          r_next.vstate = eoc_pkg::EOC_V_IDLE;
          r_next.valid  = 1'b0;
        end else if (lost) begin
          // stopped oscillator drops the flag and restarts settling
          r_next.vstate     = eoc_pkg::EOC_V_SETTLE;
          r_next.settle_cnt = 16'h0000;
          r_next.valid      = 1'b0;
        end
      end
      default: begin
        r_next.vstate = eoc_pkg::EOC_V_IDLE;
        r_next.valid  = 1'b0;
      end
    endcase

    // pin takeover follows the programmed mode
    r_next.own_in  = (r_next.mode == eoc_pkg::MODE_XTAL)
                  || (r_next.mode == eoc_pkg::MODE_XTAL_DIV2);
    r_next.own_out = (r_next.mode != eoc_pkg::MODE_OFF0)
                  && (r_next.mode != eoc_pkg::MODE_OFF1);
    r_next.osc_en  = r_next.own_out;
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_reg        <= '0;
      r_reg.mode   <= eoc_pkg::MODE_RESET;
      r_reg.fcn    <= eoc_pkg::FCN_RESET;
      r_reg.cap_en <= eoc_pkg::MEAS_RESET;
      r_reg.vstate <= eoc_pkg::EOC_V_IDLE;
      // no edge seen yet: a silent pin must not count as running
      r_reg.idle_cnt <= eoc_pkg::OSC_LOSS_CYCLES;
    end else begin
      r_reg <= r_next;
    end
  end

  // outputs straight from flops
  assign prdata                = r_reg.prdata;
  assign pready                = r_reg.pready;
  assign pslverr               = r_reg.pslverr;
  assign crystal_in_pin_owned  = r_reg.own_in;
  assign crystal_out_pin_owned = r_reg.own_out;
  assign osc_enable            = r_reg.osc_en;
  assign osc_mode              = r_reg.mode;
  assign ext_osc_freq_control  = r_reg.fcn;
  assign crystal_valid_flag    = r_reg.valid;
  assign ext_osc_div8_tick     = div_tick;

endmodule

// *** sim/eoc_osc_model.sv ***
// behavioural oscillator and rtc waveforms at the pins
`timescale 1ns/1ps
module eoc_osc_model (
  // oscillator pins
  output logic ext_osc_in,
  output logic rtc_osc_in
);
  // a stopped oscillator rests low and gives no edges
  initial begin
    ext_osc_in = 1'b0;
    rtc_osc_in = 1'b0;
  end
  // n periods of 150 ns, well below the system clock
  task automatic osc(input int n);
    repeat (n) begin
      #75 ext_osc_in = 1'b1;
      #75 ext_osc_in = 1'b0;
    end
  endtask
  // one slow rtc period for capture
  task automatic rtc();
    #300 rtc_osc_in = 1'b1;
    #300 rtc_osc_in = 1'b0;
  endtask
endmodule

// *** sim/eoc_top_sva.sv ***
// port assertions for the external oscillator control block
`timescale 1ns/1ps
module eoc_top_sva #(
  parameter int SETTLE_CYCLES = 50
) (
  // clock, reset and apb
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // pins and status
  input wire logic        crystal_in_pin_owned,
  input wire logic        crystal_out_pin_owned,
  input wire logic        osc_enable,
  input wire logic [2:0]  osc_mode,
  input wire logic        crystal_valid_flag,
  input wire logic        ext_osc_div8_tick
);
  int xtal_cnt;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // cycles spent in crystal mode, saturating so it cannot wrap
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) xtal_cnt <= 0;
    else if (osc_mode[2:1] != 2'b11) xtal_cnt <= 0;
    else if (xtal_cnt < SETTLE_CYCLES) xtal_cnt <= xtal_cnt + 1;
  end
  chk_xtal_pins: assert property (
    crystal_in_pin_owned == (osc_mode[2:1] == 2'b11)) else $error("input pin ownership wrong");
  chk_out_pin: assert property (
    crystal_out_pin_owned == (osc_mode[2:1] != 2'b00)) else $error("output pin ownership wrong");
  chk_enable_pin: assert property (
    osc_enable == crystal_out_pin_owned) else $error("enable differs from pin ownership");
  chk_valid_mode: assert property (
    $rose(crystal_valid_flag) |-> osc_mode[2:1] == 2'b11) else $error("valid outside crystal");
  chk_valid_drop: assert property (
    crystal_valid_flag && osc_mode[2:1] != 2'b11 |=> !crystal_valid_flag)
    else $error("valid kept after leaving crystal mode");
  chk_valid_settle: assert property (
    $rose(crystal_valid_flag) |-> xtal_cnt >= SETTLE_CYCLES - 1) else $error("valid too early");
  chk_tick_pulse: assert property (
    ext_osc_div8_tick |=> !ext_osc_div8_tick) else $error("tick longer than one cycle");
  chk_tick_run: assert property (
    ext_osc_div8_tick |-> $past(osc_enable)) else $error("tick while oscillator off");
  chk_one_wait: assert property (
    psel && penable && !pready |=> pready) else $error("wait state not one cycle");
  chk_ready_pulse: assert property (
    pready |=> !pready) else $error("ready longer than one cycle");
  chk_map_err: assert property (
    pready |-> pslverr == (paddr[11:4] != 8'h00 || paddr[1:0] != 2'h0))
    else $error("error response does not match address map");
  chk_err_data: assert property (
    pready && pslverr |-> prdata == 32'h0) else $error("read data not zero on error");
endmodule

bind eoc_top eoc_top_sva #(.SETTLE_CYCLES(SETTLE_CYCLES)) u_sva (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .crystal_in_pin_owned(crystal_in_pin_owned), .osc_enable(osc_enable),
  .crystal_out_pin_owned(crystal_out_pin_owned), .osc_mode(osc_mode),
  .crystal_valid_flag(crystal_valid_flag), .ext_osc_div8_tick(ext_osc_div8_tick)
);

// *** sim/tb.sv ***
// self-checking bench for the external oscillator control block
`timescale 1ns/1ps
module tb;
  localparam int          SETTLE = 50;
  localparam logic [11:0] CTRL   = eoc_pkg::OFS_CTRL;
  localparam logic [11:0] MEAS   = eoc_pkg::OFS_MEAS;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic        ext_osc_in, rtc_osc_in, xin, xout, osc_enable, valid, tick;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, a, b;
  logic [2:0]  osc_mode, fcn;
  logic [2:0]  modes [5] = '{3'h2, 3'h3, 3'h4, 3'h5, 3'h7};
  int          n_fail, checks_done, ticks;

  eoc_top #(.SETTLE_CYCLES(SETTLE)) u_eoc_top (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_osc_in(ext_osc_in), .rtc_osc_in(rtc_osc_in), .crystal_in_pin_owned(xin),
    .crystal_out_pin_owned(xout), .osc_enable(osc_enable), .osc_mode(osc_mode),
    .ext_osc_freq_control(fcn), .crystal_valid_flag(valid), .ext_osc_div8_tick(tick));
  eoc_osc_model u_eoc_osc_model (.ext_osc_in(ext_osc_in), .rtc_osc_in(rtc_osc_in));

  // 40 MHz system clock
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  // divided clock ticks seen
  always @(posedge pclk) if (tick === 1'b1) ticks++;

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 16);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (i >= 16) begin
      n_fail++;
      results();
    end
  endtask

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (8) @(posedge pclk);
    check("outs", {osc_enable, xin, xout, valid, tick, osc_mode, fcn}, 32'h0);
    presetn <= 1'b1;
    apb(0, CTRL, 0);
    check("ctrl reset", rd, 32'h0);
    // every mode, reserved and valid bits written high must read low
    for (int m = 0; m < 8; m++) begin
      apb(1, CTRL, 32'h88 | (m << 4) | m);
      apb(0, CTRL, 0);
      check("ctrl", rd, (m << 4) | m);
      check("xin", xin, m >= 6);
      check("xout", xout, m >= 2);
      check("fcn", fcn, m);
    end
    apb(1, 12'h010, 32'hFF);
    check("err", err, 1'b1);
    // divide ratio per running mode except plain xtal (6); passing through off clears the divider
    foreach (modes[k]) begin
      apb(1, CTRL, 32'h0);
      apb(1, CTRL, {25'h0, modes[k], 4'h0});
      ticks = 0;
      u_eoc_osc_model.osc(48);
      repeat (10) @(posedge pclk);
      check("ticks", ticks, (modes[k][1] & modes[k][0]) ? 3 : 6);
      check("skip pins", {xin, xout}, {modes[k][2] & modes[k][1], 1'b1});
    end
    // crystal start-up: low during settling, high after, low once stopped
    apb(1, CTRL, 32'h0);
    @(posedge pclk);
    check("pins free", {xin, xout}, 2'b00);
    apb(1, CTRL, 32'h67);
    fork
      u_eoc_osc_model.osc(100);
      begin
        repeat (SETTLE - 10) @(posedge pclk);
        check("early", valid, 1'b0);
        check("pins taken", {xin, xout}, 2'b11);
      end
    join
    apb(0, CTRL, 0);
    check("ctrl valid", rd, 32'hE7);
    repeat (4100) @(posedge pclk);
    check("lost", valid, 1'b0);
    // capture against the rtc: both enabled, then only the first
    apb(1, MEAS, 32'h3);
    u_eoc_osc_model.rtc();
    apb(0, eoc_pkg::OFS_CAP0, 0);
    a = rd;
    apb(0, eoc_pkg::OFS_CAP1, 0);
    b = rd;
    u_eoc_osc_model.osc(40);
    u_eoc_osc_model.rtc();
    apb(1, eoc_pkg::OFS_CAP0, 32'h5);
    apb(0, eoc_pkg::OFS_CAP0, 0);
    check("cap0", (rd - a) & 32'hFFFF, 40);
    apb(0, eoc_pkg::OFS_CAP1, 0);
    check("cap1", (rd - b) & 32'hFFFF, 40);
    b = rd;
    apb(1, MEAS, 32'h1);
    apb(0, MEAS, 0);
    check("meas", rd, 32'h1);
    u_eoc_osc_model.osc(8);
    u_eoc_osc_model.rtc();
    apb(0, eoc_pkg::OFS_CAP1, 0);
    check("cap1 held", rd, b);
    results();
  end
endmodule
